// [logic/pirq_pkg.sv]
package pirq_pkg;
  // register byte offsets on the apb slave
  localparam logic [7:0] PIRQ_OFF_FLAGS3 = 8'h00;
  localparam logic [7:0] PIRQ_OFF_FLAGS4 = 8'h04;
  localparam logic [7:0] PIRQ_OFF_EN3 = 8'h08;
  localparam logic [7:0] PIRQ_OFF_EN4 = 8'h0C;
  localparam logic [7:0] PIRQ_OFF_CORE = 8'h10;
  localparam logic [7:0] PIRQ_OFF_EVSTAT = 8'h14;
  localparam logic [7:0] PIRQ_OFF_EVMASK = 8'h18;
  // flag positions
  localparam int PIRQ_B_TMR4 = 1;
  localparam int PIRQ_B_TMR6 = 3;
  localparam int PIRQ_B_CMP3 = 4;
  localparam int PIRQ_B_CMP4 = 5;
  localparam int PIRQ_B_COLL = 1;
  localparam int PIRQ_B_DONE = 0;
  localparam int PIRQ_B_PERIPHERAL_INTERRUPT_ENABLE = 6;
  localparam int PIRQ_B_GIE = 7;
  // implemented-bit masks
  localparam logic [7:0] PIRQ_MASK3 = 8'h3A;
  localparam logic [7:0] PIRQ_MASK4 = 8'h03;
  localparam logic [7:0] PIRQ_MASK_CORE = 8'hC0;
  localparam logic [7:0] PIRQ_RESET8 = 8'h00;
  localparam logic [31:0] PIRQ_ZERO32 = 32'h0000_0000;
  // event status bit layout
  localparam int PIRQ_EV_NUM = 6;
endpackage

// [logic/pirq_if.sv]
`timescale 1ns/10ps
interface pirq_if;
  logic [7:0] flags3;
  logic [7:0] flags4;
  logic [7:0] en3;
  logic [7:0] en4;
  logic peripheral_interrupt_enable;
  logic global_interrupt_enable;
  logic req;
  modport ctrl (output flags3, output flags4, output en3, output en4, output peripheral_interrupt_enable, output global_interrupt_enable, input req);
  modport comb (input flags3, input flags4, input en3, input en4, input peripheral_interrupt_enable, input global_interrupt_enable, output req);
endinterface

// [logic/pirq_req.sv]
`timescale 1ns/10ps
module pirq_req (
  input wire logic clk,
  input wire logic nrst,
  pirq_if.comb bus
);
  import pirq_pkg::*;
  logic req_q;
  // registered so the cpu request is glitch free
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_q <= 1'b0;
    end else begin
      req_q <= bus.peripheral_interrupt_enable && (|((bus.flags3 & bus.en3) | (bus.flags4 & bus.en4)));
    end
  end
  assign bus.req = req_q;
endmodule // pirq_req

// [logic/pirq_top.sv]
`timescale 1ns/10ps
module pirq_top #(
  parameter bit HAS_PORT4 = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic compare3_event,
  input wire logic compare4_event,
  input wire logic timer4_match_event,
  input wire logic timer6_match_event,
  input wire logic serial2_collision_event,
  input wire logic serial2_done_event,
  output logic periph_irq_req,
  output logic event_irq
);
  import pirq_pkg::*;
  pirq_if link ();
  logic [7:0] flags3_q;
  logic [7:0] flags4_q;
  logic [7:0] en3_q;
  logic [7:0] en4_q;
  logic [7:0] core_q;
  logic [PIRQ_EV_NUM-1:0] evstat_q;
  logic [PIRQ_EV_NUM-1:0] evmask_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic [7:0] set3;
  logic [7:0] set4;
  logic [7:0] mask4;
  logic [PIRQ_EV_NUM-1:0] ev_vec;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic [7:0] wbyte;
  // next-state values, one per register
  logic [7:0] flags3_d;
  logic [7:0] flags4_d;
  logic [7:0] en3_d;
  logic [7:0] en4_d;
  logic [7:0] core_d;
  logic [PIRQ_EV_NUM-1:0] evstat_d;
  logic [PIRQ_EV_NUM-1:0] evmask_d;
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  logic irq_d;
  logic setup_rd;
  logic hit_flags3;
  logic hit_flags4;
  logic hit_en3;
  logic hit_en4;
  logic hit_core;
  logic hit_evstat;
  logic hit_evmask;

  assign acc = psel && penable && pready_q;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign wbyte = pwdata[7:0];
  assign mask4 = HAS_PORT4 ? PIRQ_MASK4 : PIRQ_RESET8;

  // address decode for the write paths and the evstat read clear; read data decodes paddr in its own case
  assign hit_flags3 = paddr == PIRQ_OFF_FLAGS3;
  assign hit_flags4 = paddr == PIRQ_OFF_FLAGS4;
  assign hit_en3 = paddr == PIRQ_OFF_EN3;
  assign hit_en4 = paddr == PIRQ_OFF_EN4;
  assign hit_core = paddr == PIRQ_OFF_CORE;
  assign hit_evstat = paddr == PIRQ_OFF_EVSTAT;
  assign hit_evmask = paddr == PIRQ_OFF_EVMASK;
  // first access cycle of a read
  assign setup_rd = psel && penable && !pready_q && !pwrite;

  // a condition held for several cycles just sets its flag again
  always_comb begin
    set3 = PIRQ_RESET8;
    set3[PIRQ_B_CMP4] = compare4_event;
    set3[PIRQ_B_CMP3] = compare3_event;
    set3[PIRQ_B_TMR6] = timer6_match_event;
    set3[PIRQ_B_TMR4] = timer4_match_event;
    set4 = PIRQ_RESET8;
    set4[PIRQ_B_COLL] = serial2_collision_event;
    set4[PIRQ_B_DONE] = serial2_done_event;
  end

  // event status order: timer4, timer6, compare3, compare4, serial2 done, serial2 collision
  assign ev_vec[0] = set3[PIRQ_B_TMR4];
  assign ev_vec[1] = set3[PIRQ_B_TMR6];
  assign ev_vec[2] = set3[PIRQ_B_CMP3];
  assign ev_vec[3] = set3[PIRQ_B_CMP4];
  // serial2 events count only where the fourth register exists
  assign ev_vec[4] = set4[PIRQ_B_DONE] & mask4[PIRQ_B_DONE];
  assign ev_vec[5] = set4[PIRQ_B_COLL] & mask4[PIRQ_B_COLL];

  // unmapped offsets answer with an error and change nothing
  always_comb begin
    case (paddr)
      PIRQ_OFF_FLAGS3, PIRQ_OFF_FLAGS4, PIRQ_OFF_EN3, PIRQ_OFF_EN4,
      PIRQ_OFF_CORE, PIRQ_OFF_EVSTAT, PIRQ_OFF_EVMASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // one wait state: setup, access with pready low, then access with pready high
  always_comb begin
    pready_d = psel && penable && !pready_q;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
    end
  end

  // event sets win over software writes in the same cycle, so a flag
  // is never lost to a clear that races its event
  always_comb begin
    flags3_d = flags3_q;
    if (wr && hit_flags3) begin
      flags3_d = wbyte;
    end
    flags3_d = flags3_d | set3;
    flags3_d = flags3_d & PIRQ_MASK3;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags3_q <= PIRQ_RESET8;
    end else begin
      flags3_q <= flags3_d;
    end
  end

  // serial2 flags stay set until software writes a zero
  always_comb begin
    flags4_d = flags4_q;
    if (wr && hit_flags4) begin
      flags4_d = wbyte;
    end
    flags4_d = flags4_d | set4;
    flags4_d = flags4_d & mask4;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags4_q <= PIRQ_RESET8;
    end else begin
      flags4_q <= flags4_d;
    end
  end

  always_comb begin
    en3_d = en3_q;
    if (wr && hit_en3) begin
      en3_d = wbyte & PIRQ_MASK3;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en3_q <= PIRQ_RESET8;
    end else begin
      en3_q <= en3_d;
    end
  end

  always_comb begin
    en4_d = en4_q;
    if (wr && hit_en4) begin
      en4_d = wbyte & mask4;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en4_q <= PIRQ_RESET8;
    end else begin
      en4_q <= en4_d;
    end
  end

  // global enable is only stored; the cpu core applies its own gating
  always_comb begin
    core_d = core_q;
    if (wr && hit_core) begin
      core_d = wbyte & PIRQ_MASK_CORE;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_q <= PIRQ_RESET8;
    end else begin
      core_q <= core_d;
    end
  end

  always_comb begin
    evmask_d = evmask_q;
    if (wr && hit_evmask) begin
      evmask_d = wbyte[PIRQ_EV_NUM-1:0];
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evmask_q <= '0;
    end else begin
      evmask_q <= evmask_d;
    end
  end

  // a read clears only the bits it reported, so an event that lands
  // between the data fetch and the end of the read waits for the next read
  always_comb begin
    evstat_d = evstat_q;
    if (rd && hit_evstat) begin
      evstat_d = evstat_q & ~prdata_q[PIRQ_EV_NUM-1:0];
    end
    evstat_d = evstat_d | ev_vec;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evstat_q <= '0;
    end else begin
      evstat_q <= evstat_d;
    end
  end

  always_comb begin
    irq_d = |(evstat_q & evmask_q);
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // read data is fetched in the first access cycle so it stands with pready
  // pslverr rides with pready; a write to an unmapped offset is dropped
  always_comb begin
    prdata_d = PIRQ_ZERO32;
    pslverr_d = psel && penable && !pready_q && !mapped;
    if (setup_rd) begin
      case (paddr)
        PIRQ_OFF_FLAGS3: prdata_d = {24'h000000, flags3_q};
        PIRQ_OFF_FLAGS4: prdata_d = {24'h000000, flags4_q};
        PIRQ_OFF_EN3: prdata_d = {24'h000000, en3_q};
        PIRQ_OFF_EN4: prdata_d = {24'h000000, en4_q};
        PIRQ_OFF_CORE: prdata_d = {24'h000000, core_q};
        PIRQ_OFF_EVSTAT: prdata_d = {26'h0, evstat_q};
        PIRQ_OFF_EVMASK: prdata_d = {26'h0, evmask_q};
        default: prdata_d = PIRQ_ZERO32;
      endcase
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= PIRQ_ZERO32;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign link.flags3 = flags3_q;
  assign link.flags4 = flags4_q;
  assign link.en3 = en3_q;
  assign link.en4 = en4_q;
  assign link.peripheral_interrupt_enable = core_q[PIRQ_B_PERIPHERAL_INTERRUPT_ENABLE];
  assign link.global_interrupt_enable = core_q[PIRQ_B_GIE];
  // request gating sits in its own module behind the interface
  pirq_req u_req (
    .clk(clk),
    .nrst(nrst),
    .bus(link.comb)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign periph_irq_req = link.req;
  assign event_irq = irq_q;
endmodule // pirq_top

// [verification/pirq_props.sv]
`timescale 1ns/10ps
module pirq_props
  import pirq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic compare3_event,
  input wire logic compare4_event
);
  logic rd_ok;
  assign rd_ok = pready && !pslverr && !pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_READY_LAT: assert property ((psel && !penable) |=> !pready ##1 pready)
    else $error("pready late");
  AST_READY_ONE: assert property (pready |=> !pready) else $error("pready long");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  AST_ERR_PAIR: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad pslverr");
  AST_F3_UNUSED: assert property (rd_ok && paddr == PIRQ_OFF_FLAGS3 |-> (prdata & ~32'h3A) == 32'h0)
    else $error("flags3 spare bits");
  AST_F4_UNUSED: assert property (rd_ok && paddr == PIRQ_OFF_FLAGS4 |-> (prdata & ~32'h03) == 32'h0)
    else $error("flags4 spare bits");
  AST_CMP4_SET: assert property (rd_ok && paddr == PIRQ_OFF_FLAGS3 && $past(compare4_event, 2) |-> prdata[5])
    else $error("compare4 flag lost");
  AST_CMP3_SET: assert property (rd_ok && paddr == PIRQ_OFF_FLAGS3 && $past(compare3_event, 2) |-> prdata[4])
    else $error("compare3 flag lost");
endmodule // pirq_props

bind pirq_top pirq_props u_props (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .compare3_event(compare3_event),
  .compare4_event(compare4_event));

// [verification/pirq_periph.sv]
`timescale 1ns/10ps
module pirq_periph (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [5:0] fire,
  output logic [5:0] ev
);
  // one-cycle condition pulses, like real peripherals
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) ev <= 6'h00;
    else ev <= fire;
  end
endmodule // pirq_periph

// [verification/peripheral_irq_flags_3_4_tb.sv]
`timescale 1ns/10ps
module peripheral_irq_flags_3_4_tb;
  import pirq_pkg::*;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq, evirq, err, irq_s;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, prdata_s, rd_s;
  logic [5:0] fire, ev;
  int mismatches, checked;
  pirq_top #(.HAS_PORT4(1'b1)) DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare3_event(ev[0]), .compare4_event(ev[1]), .timer4_match_event(ev[2]), .timer6_match_event(ev[3]),
    .serial2_collision_event(ev[4]), .serial2_done_event(ev[5]), .periph_irq_req(irq), .event_irq(evirq));
  pirq_periph u_periph (.clk(clk), .nrst(nrst), .fire(fire), .ev(ev));
  // small variant without the fourth register, fed the same bus and events
  pirq_top #(.HAS_PORT4(1'b0)) u_small (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata_s), .pready(), .pslverr(),
    .compare3_event(ev[0]), .compare4_event(ev[1]), .timer4_match_event(ev[2]), .timer6_match_event(ev[3]),
    .serial2_collision_event(ev[4]), .serial2_done_event(ev[5]), .periph_irq_req(irq_s), .event_irq());
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task stop_test;
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      stop_test;
    end
    rd = prdata;
    rd_s = prdata_s;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // request outputs lag state by one cycle
  task lvl(input logic [1:0] exp);
    repeat (2) @(posedge clk);
    chk({30'h0, irq, evirq}, {30'h0, exp});
  endtask
  task pulse(input logic [5:0] m);
    fire <= m;
    @(posedge clk);
    fire <= 6'h00;
    repeat (3) @(posedge clk);
  endtask
  task s_reset;
    rchk(PIRQ_OFF_FLAGS3, 32'h0);
    rchk(PIRQ_OFF_FLAGS4, 32'h0);
    rchk(PIRQ_OFF_EN4, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk({rd[31:1], err}, 32'h1);
  endtask
  task s_flags;
    fire <= 6'h3F;
    @(posedge clk);
    fire <= 6'h00;
    rchk(PIRQ_OFF_FLAGS3, 32'h3A);
    rchk(PIRQ_OFF_FLAGS4, 32'h03);
    chk(rd_s, 32'h0);
    lvl(2'b00);
    apb(1'b1, PIRQ_OFF_FLAGS3, 32'hFF);
    rchk(PIRQ_OFF_FLAGS3, 32'h3A);
    apb(1'b1, PIRQ_OFF_FLAGS4, 32'hFC);
    rchk(PIRQ_OFF_FLAGS4, 32'h0);
    apb(1'b1, PIRQ_OFF_FLAGS3, 32'h0);
  endtask
  task s_irq;
    apb(1'b1, PIRQ_OFF_EN4, 32'h02);
    apb(1'b1, PIRQ_OFF_CORE, 32'h40);
    pulse(6'h20);
    lvl(2'b00);
    pulse(6'h10);
    lvl(2'b10);
    chk({31'h0, irq_s}, 32'h0);
    apb(1'b1, PIRQ_OFF_CORE, 32'h80);
    lvl(2'b00);
    rchk(PIRQ_OFF_CORE, 32'h80);
    apb(1'b1, PIRQ_OFF_CORE, 32'h40);
    lvl(2'b10);
    apb(1'b1, PIRQ_OFF_EN4, 32'h0);
    lvl(2'b00);
    apb(1'b1, PIRQ_OFF_EN3, 32'h20);
    fire <= 6'h02;
    @(posedge clk);
    fire <= 6'h00;
    rchk(PIRQ_OFF_FLAGS3, 32'h20);
    lvl(2'b10);
  endtask
  task s_event;
    rchk(PIRQ_OFF_EVSTAT, 32'h3F);
    apb(1'b1, PIRQ_OFF_EVMASK, 32'h01);
    apb(1'b1, PIRQ_OFF_CORE, 32'h0);
    pulse(6'h08);
    lvl(2'b00);
    pulse(6'h04);
    lvl(2'b01);
    rchk(PIRQ_OFF_EVSTAT, 32'h03);
    lvl(2'b00);
  endtask
  // mid-run reset with flags and enables still set
  task s_rerst;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rchk(PIRQ_OFF_FLAGS3, 32'h0);
    rchk(PIRQ_OFF_FLAGS4, 32'h0);
    rchk(PIRQ_OFF_EN3, 32'h0);
  endtask
  initial begin
    mismatches = 0;
    checked = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fire = 6'h00;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    s_reset;
    s_flags;
    s_irq;
    s_event;
    s_rerst;
    stop_test;
  end
endmodule // peripheral_irq_flags_3_4_tb
